// ---- include/prf_pkg.sv ----
/*
  Shared constants and carrier types for the peripheral register framework:
  register offsets inside the 16-Kbyte serial port window, field positions,
  reset values and the bus request and transfer channel structs.
  Assumes a simple synchronous word bus from the peripheral bridge, one
  request per cycle, with read data taken one cycle after the request.
*/
// Contract
// [R1] each peripheral decodes a 16-Kbyte window; interrupt controller window only 4 Kbytes
// [R2] control register is write-only; a one launches its command, zero does nothing
// [R3] configuration register is read/write and resets to all zeros
// [R4] status register is read-only; writes never change it
// [R5] a one written to the set register sets the matching status bit
// [R6] a one written to the clear register clears the status bit; zeros change nothing
// [R7] unassigned bits read zero; software writes zero to them
// [R8] interrupt source is OR over all bits of status AND mask
// [R9] mask is readable, changed only by enable-set and disable-clear registers
// [R10] four transfer channels: receive and transmit for each of two serial ports
// [R11] each channel has a 32-bit address pointer and 16-bit remaining counter
// [R12] when a channel finishes its count, an end-of-transfer status flag is set
// [R13] only word accesses; low address bits ignored for byte or halfword access
// [R14] each transfer advances pointer by transfer size, decrements counter, stops at zero
package prf_pkg;

  // ----------------------------------------------------------------
  // address window
  // ----------------------------------------------------------------
  localparam int unsigned PRF_ADDR_W = 32;
  localparam int unsigned PRF_WIN_BITS = 14;
  localparam int unsigned PRF_IRQC_WIN_BITS = 12;
  localparam int unsigned PRF_WORD_LSB = 2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses inside the window)
  // ----------------------------------------------------------------
  localparam logic [13:0] PRF_OFF_CTRL = 14'h0000;
  localparam logic [13:0] PRF_OFF_CFG = 14'h0004;
  localparam logic [13:0] PRF_OFF_STAT_SET = 14'h0008;
  localparam logic [13:0] PRF_OFF_STAT_CLR = 14'h000c;
  localparam logic [13:0] PRF_OFF_STAT = 14'h0010;
  localparam logic [13:0] PRF_OFF_INT_EN = 14'h0014;
  localparam logic [13:0] PRF_OFF_INT_DIS = 14'h0018;
  localparam logic [13:0] PRF_OFF_INT_MASK = 14'h001c;
  localparam logic [13:0] PRF_OFF_RX_PTR = 14'h0030;
  localparam logic [13:0] PRF_OFF_RX_CNT = 14'h0034;
  localparam logic [13:0] PRF_OFF_TX_PTR = 14'h0038;
  localparam logic [13:0] PRF_OFF_TX_CNT = 14'h003c;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int unsigned PRF_STAT_W = 8;
  localparam int unsigned PRF_CFG_W = 8;
  localparam int unsigned PRF_CNT_W = 16;
  localparam int unsigned PRF_BIT_RX_END = 0;
  localparam int unsigned PRF_BIT_TX_END = 1;
  localparam int unsigned PRF_BIT_USER = 2;
  localparam logic [PRF_STAT_W-1:0] PRF_STAT_HW_MASK = 8'h03;
  localparam int unsigned PRF_CTRL_RX_RESET = 0;
  localparam int unsigned PRF_CTRL_TX_RESET = 1;
  localparam int unsigned PRF_CTRL_W = 2;
  localparam logic [PRF_CFG_W-1:0] PRF_CFG_RESET = 8'h00;
  localparam logic [PRF_STAT_W-1:0] PRF_STAT_RESET = 8'h00;
  localparam logic [31:0] PRF_PTR_RESET = 32'h0000_0000;
  localparam logic [PRF_CNT_W-1:0] PRF_CNT_RESET = 16'h0000;
  localparam logic [31:0] PRF_XFER_SIZE = 32'h0000_0001;
  localparam int unsigned PRF_NUM_PORTS = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic write;
    logic [PRF_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } prf_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } prf_xfer_t;

endpackage

// ---- design/prf_window_decode.sv ----
/*
  Address window decoder for one peripheral slot.
  Assumes the bridge supplies a full byte address; base is window aligned.
*/
module prf_window_decode #(
  parameter int unsigned WIN_BITS = prf_pkg::PRF_WIN_BITS,
  parameter logic [31:0] BASE = 32'hfffc_0000
) (
  input wire logic [prf_pkg::PRF_ADDR_W-1:0] addr,
  output logic hit,
  output logic [13:0] offset
);
  import prf_pkg::*;

  logic [31:0] win_mask;

  assign win_mask = ~((32'h0000_0001 << WIN_BITS) - 32'h0000_0001);
  // low bits dropped so narrow accesses act as word accesses
  assign hit = (addr & win_mask) == (BASE & win_mask); // [R1]
  assign offset = {addr[13:PRF_WORD_LSB], 2'b00} & 14'((32'h0000_0001 << WIN_BITS) - 32'h0000_0001); // [R13]
endmodule

// ---- design/prf_xfer_channel.sv ----
/*
  One transfer channel: address pointer and remaining-transfer counter.
  Assumes the serial port pulses xfer_done once per completed data move.
*/
module prf_xfer_channel #(
  parameter int unsigned CNT_W = prf_pkg::PRF_CNT_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ptr_we,
  input wire logic cnt_we,
  input wire logic [31:0] wdata,
  input wire logic xfer_done,
  output logic [31:0] ptr,
  output logic [CNT_W-1:0] cnt,
  output logic active,
  output logic end_pulse
);
  import prf_pkg::*;

  assign active = cnt != '0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr <= PRF_PTR_RESET;
    end else if (ptr_we) begin
      ptr <= wdata;
    end else if (xfer_done && active) begin
      ptr <= ptr + PRF_XFER_SIZE; // [R14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= CNT_W'(PRF_CNT_RESET);
    end else if (cnt_we) begin
      cnt <= wdata[CNT_W-1:0];
    end else if (xfer_done && active) begin
      cnt <= cnt - CNT_W'(1); // [R14]
    end
  end

  // end event on the last move only; reloading a count never fires it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      end_pulse <= 1'b0;
    end else begin
      end_pulse <= xfer_done && !cnt_we && cnt == CNT_W'(1); // [R12]
    end
  end
endmodule

// ---- design/prf_serial_regs.sv ----
/*
  Register bank of one serial port slot: control, configuration, set/clear
  status, interrupt enable/disable/mask and two transfer channels.
  Assumes a single-cycle word bus: request on one edge, read data and ack on
  the next. The interrupt source goes to the vectored_interrupt_controller.
*/
module prf_serial_regs #(
  parameter logic [31:0] BASE = 32'hfffc_0000,
  parameter int unsigned STAT_W = prf_pkg::PRF_STAT_W,
  parameter int unsigned CFG_W = prf_pkg::PRF_CFG_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire prf_pkg::prf_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_ack,
  output logic bus_hit,
  input wire logic rx_done,
  input wire logic tx_done,
  output logic [CFG_W-1:0] cfg,
  output logic [prf_pkg::PRF_CTRL_W-1:0] cmd_pulse,
  output prf_pkg::prf_xfer_t rx_xfer,
  output prf_pkg::prf_xfer_t tx_xfer,
  output logic irq_source
);
  import prf_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic hit;
  logic [13:0] offset;
  logic wr;
  logic rd;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [31:0] rx_ptr;
  logic [31:0] tx_ptr;
  logic [PRF_CNT_W-1:0] rx_cnt;
  logic [PRF_CNT_W-1:0] tx_cnt;
  logic rx_active;
  logic tx_active;
  logic rx_end;
  logic tx_end;
  logic [STAT_W-1:0] hw_set;
  logic [31:0] next_rdata;

  prf_window_decode #(
    .WIN_BITS(PRF_WIN_BITS),
    .BASE(BASE)
  ) u_decode (
    .addr(bus_req.addr),
    .hit(hit),
    .offset(offset)
  );

  assign wr = bus_req.sel && bus_req.write && hit;
  assign rd = bus_req.sel && !bus_req.write && hit;

  function automatic logic wr_at(input logic [13:0] off);
    return wr && offset == off;
  endfunction

  // ----------------------------------------------------------------
  // transfer channels
  // ----------------------------------------------------------------
  prf_xfer_channel #(
    .CNT_W(PRF_CNT_W)
  ) u_rx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ptr_we(wr_at(PRF_OFF_RX_PTR)),
    .cnt_we(wr_at(PRF_OFF_RX_CNT)),
    .wdata(bus_req.wdata),
    .xfer_done(rx_done),
    .ptr(rx_ptr),
    .cnt(rx_cnt),
    .active(rx_active),
    .end_pulse(rx_end)
  ); // [R10] [R11]

  prf_xfer_channel #(
    .CNT_W(PRF_CNT_W)
  ) u_tx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ptr_we(wr_at(PRF_OFF_TX_PTR)),
    .cnt_we(wr_at(PRF_OFF_TX_CNT)),
    .wdata(bus_req.wdata),
    .xfer_done(tx_done),
    .ptr(tx_ptr),
    .cnt(tx_cnt),
    .active(tx_active),
    .end_pulse(tx_end)
  ); // [R10] [R11]

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_xfer <= '0;
      tx_xfer <= '0;
    end else begin
      rx_xfer <= '{valid: rx_active, addr: rx_ptr};
      tx_xfer <= '{valid: tx_active, addr: tx_ptr};
    end
  end

  // ----------------------------------------------------------------
  // control and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_pulse <= '0;
    end else if (wr_at(PRF_OFF_CTRL)) begin
      cmd_pulse <= bus_req.wdata[PRF_CTRL_W-1:0]; // [R2]
    end else begin
      cmd_pulse <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg <= PRF_CFG_RESET; // [R3]
    end else if (wr_at(PRF_OFF_CFG)) begin
      cfg <= bus_req.wdata[CFG_W-1:0]; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // status and mask
  // ----------------------------------------------------------------
  always_comb begin
    hw_set = '0;
    hw_set[PRF_BIT_RX_END] = rx_end; // [R12]
    hw_set[PRF_BIT_TX_END] = tx_end; // [R12]
  end

  // hardware set beats a same-cycle software clear so no end event is lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status <= PRF_STAT_RESET;
    end else begin
      status <= ((status
                 | (wr_at(PRF_OFF_STAT_SET) ? bus_req.wdata[STAT_W-1:0] : '0)) // [R5]
                 & ~(wr_at(PRF_OFF_STAT_CLR) ? bus_req.wdata[STAT_W-1:0] : '0)) // [R6]
                 | hw_set; // [R4]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask <= '0;
    end else begin
      mask <= (mask | (wr_at(PRF_OFF_INT_EN) ? bus_req.wdata[STAT_W-1:0] : '0))
              & ~(wr_at(PRF_OFF_INT_DIS) ? bus_req.wdata[STAT_W-1:0] : '0); // [R9]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_source <= 1'b0;
    end else begin
      irq_source <= |(status & mask); // [R8]
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // write-only and unmapped words read zero, as do unused upper bits
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (offset)
      PRF_OFF_CFG: next_rdata[CFG_W-1:0] = cfg; // [R3]
      PRF_OFF_STAT: next_rdata[STAT_W-1:0] = status; // [R4]
      PRF_OFF_INT_MASK: next_rdata[STAT_W-1:0] = mask; // [R9]
      PRF_OFF_RX_PTR: next_rdata = rx_ptr; // [R11]
      PRF_OFF_RX_CNT: next_rdata[PRF_CNT_W-1:0] = rx_cnt; // [R11] [R7]
      PRF_OFF_TX_PTR: next_rdata = tx_ptr; // [R11]
      PRF_OFF_TX_CNT: next_rdata[PRF_CNT_W-1:0] = tx_cnt; // [R11] [R7]
      default: next_rdata = 32'h0000_0000; // [R7]
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0000_0000;
      bus_ack <= 1'b0;
      bus_hit <= 1'b0;
    end else begin
      bus_rdata <= rd ? next_rdata : 32'h0000_0000;
      bus_ack <= bus_req.sel && hit;
      bus_hit <= hit;
    end
  end
endmodule

// ---- testbench/prf_serial_regs_assertions.sv ----
/* Checker for prf_serial_regs port behaviour.
   Assumes it is bound to the top module and sees its ports only. */
module prf_serial_regs_chk import prf_pkg::*; #(
  parameter logic [31:0] BASE = 32'hfffc_0000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire prf_pkg::prf_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic [7:0] cfg,
  input wire logic [prf_pkg::PRF_CTRL_W-1:0] cmd_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // word-level request decode
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic hit;
  logic rd;
  logic [11:0] w;
  assign hit = bus_req.sel && bus_req.addr[31:14] == BASE[31:14];
  assign rd = hit && !bus_req.write;
  assign w = bus_req.addr[13:2];
  AST_ACK: assert property (hit |=> bus_ack) else $error("missing ack");
  AST_NOACK: assert property (!hit |=> !bus_ack) else $error("ack outside window");
  AST_CMD: assert property (hit && bus_req.write && w == 12'h0 |=> cmd_pulse == $past(bus_req.wdata[1:0]))
    else $error("command pulse wrong");
  AST_CMD_IDLE: assert property (!(hit && bus_req.write && w == 12'h0) |=> cmd_pulse == 2'h0)
    else $error("command without write");
  AST_CFG: assert property (hit && bus_req.write && w == 12'h1 |=> cfg == $past(bus_req.wdata[7:0]))
    else $error("cfg not written");
  AST_CFG_HOLD: assert property (!(hit && bus_req.write && w == 12'h1) |=> $stable(cfg))
    else $error("cfg changed");
  AST_CFG_RD: assert property (rd && w == 12'h1 |=> bus_rdata == {24'h0, cfg}) else $error("cfg readback");
  AST_RD_ZERO: assert property (rd && (w == 12'h0 || w inside {[8:11]}) |=> bus_rdata == 32'h0)
    else $error("write-only or unused reads nonzero");
  AST_CNT_W: assert property (rd && (w == 12'hd || w == 12'hf) |=> bus_rdata[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  AST_WR_NODATA: assert property (hit && bus_req.write |=> bus_rdata == 32'h0)
    else $error("read data on a write");
endmodule

// ---- testbench/prf_port_model.sv ----
/* Serial port stand-in: one done strobe per data move while a channel
   reports work pending. Assumes gap of 3 or more cycles. */
module prf_port_model import prf_pkg::*; (
  input wire logic clk_sys,
  input wire logic [3:0] gap,
  input wire prf_pkg::prf_xfer_t rx_xfer,
  input wire prf_pkg::prf_xfer_t tx_xfer,
  output logic rx_done = 1'b0,
  output logic tx_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // move pacing
  // ----
  logic [3:0] tick = 4'h0;
  // valid lags the counter a cycle, so spacing avoids a move past zero
  always @(posedge clk_sys) begin
    tick <= (tick >= gap) ? 4'h0 : tick + 4'h1;
    rx_done <= rx_xfer.valid && tick == gap;
    tx_done <= tx_xfer.valid && tick == gap;
  end
endmodule

// ---- testbench/prf_serial_regs_tb_top.sv ----
/* Bench top for prf_serial_regs: word bus driven at falling edges,
   port model supplies transfers. Assumes the default window base. */
module prf_serial_regs_tb_top import prf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // harness
  // ----
  localparam logic [31:0] BASE = 32'hfffc_0000;
  logic clk_sys = 1'b0;
  logic sys_rst;
  prf_req_t bus_req = '0;
  logic [3:0] gap = 4'h3;
  logic [31:0] bus_rdata, rd;
  logic bus_ack, bus_hit, rx_done, tx_done, irq_source;
  logic [7:0] cfg;
  logic [1:0] cmd_pulse;
  prf_xfer_t rx_xfer, tx_xfer;
  int miscompares = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  prf_serial_regs #(.BASE(BASE)) u_prf_serial_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_hit(bus_hit), .rx_done(rx_done), .tx_done(tx_done),
    .cfg(cfg), .cmd_pulse(cmd_pulse), .rx_xfer(rx_xfer), .tx_xfer(tx_xfer), .irq_source(irq_source));
  prf_port_model u_prf_port_model (.clk_sys(clk_sys), .gap(gap), .rx_xfer(rx_xfer), .tx_xfer(tx_xfer),
    .rx_done(rx_done), .tx_done(tx_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request stays up until the next call or idle, so no double drive
  task automatic acc(input logic w, input logic [15:0] off, input logic [31:0] wd, input logic ak = 1'b1);
    bus_req = '{1'b1, w, BASE + 32'(off), wd};
    @(negedge clk_sys);
    chk({30'h0, bus_ack, bus_hit}, {30'h0, ak, ak});
    rd = bus_rdata;
  endtask
  task automatic idle();
    bus_req.sel = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rst();
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    for (int o = 0; o < 64; o += 4) begin
      acc(1'b0, 16'(o), '0);
      chk(rd, '0);
    end
    acc(1'b0, 16'h4010, '0, 1'b0);
    idle();
  endtask
  task automatic t_cfg_ctrl();
    acc(1'b1, 16'h0007, 32'h5a);
    chk(32'(cfg), 32'h5a);
    acc(1'b0, 16'h0006, '0);
    chk(rd, 32'h5a);
    for (int c = 1; c < 3; c++) begin
      acc(1'b1, 16'h0003, 32'(c));
      chk(32'(cmd_pulse), 32'(c));
    end
    acc(1'b1, 16'h0000, 32'h0);
    chk(32'(cmd_pulse), 32'h0);
    acc(1'b0, 16'h0000, '0);
    chk(rd, '0);
  endtask
  task automatic t_status();
    acc(1'b1, 16'h0008, 32'h0c);
    acc(1'b1, 16'h000c, 32'h04);
    acc(1'b1, 16'h0008, 32'h0);
    acc(1'b1, 16'h0010, 32'hff);
    acc(1'b0, 16'h0010, '0);
    chk(rd, 32'h08);
    acc(1'b1, 16'h0014, 32'h0c);
    acc(1'b1, 16'h001c, 32'hff);
    acc(1'b0, 16'h001c, '0);
    chk(rd, 32'h0c);
    chk(32'(irq_source), 32'h1);
    acc(1'b1, 16'h000c, 32'h08);
    idle();
    chk(32'(irq_source), 32'h0);
    acc(1'b1, 16'h0018, 32'h0c);
    acc(1'b0, 16'h001c, '0);
    chk(rd, 32'h0);
  endtask
  task automatic t_chan(input int ch);
    logic [15:0] po;
    po = 16'h30 + 16'(8 * ch);
    gap = ch ? 4'h7 : 4'h3;
    acc(1'b1, 16'h0014, 32'(1 << ch));
    acc(1'b1, po, 32'h100);
    acc(1'b1, po + 16'h4, 32'h2);
    idle();
    // no move can have landed yet: the model needs two more edges
    chk(32'(ch ? tx_xfer.valid : rx_xfer.valid), 32'h1);
    chk(ch ? tx_xfer.addr : rx_xfer.addr, 32'h100);
    for (int i = 0; i < 60 && irq_source !== 1'b1; i++) @(negedge clk_sys);
    chk(32'(irq_source), 32'h1);
    chk(32'(ch ? tx_xfer.valid : rx_xfer.valid), 32'h0);
    acc(1'b0, po, '0);
    chk(rd, 32'h102);
    acc(1'b0, po + 16'h4, '0);
    chk(rd, 32'h0);
    acc(1'b0, 16'h0010, '0);
    chk(rd, 32'(1 << ch));
    acc(1'b1, 16'h000c, 32'h3);
    acc(1'b1, 16'h0018, 32'h3);
    idle();
  endtask
  initial begin
    rst();
    t_reset();
    t_cfg_ctrl();
    t_status();
    t_chan(0);
    t_chan(1);
    rst();
    acc(1'b0, 16'h0004, '0);
    chk(rd, '0);
    final_report();
  end
  initial begin
    #100us;
    miscompares++;
    final_report();
  end
endmodule
bind prf_serial_regs prf_serial_regs_chk #(.BASE(BASE)) u_prf_serial_regs_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .cfg(cfg),
  .cmd_pulse(cmd_pulse));
